// File: hbc_pkg.sv
// Purpose: Constants for the H-bridge control and protection block.
// Assumes: 40 MHz core clock; comparator and pin inputs arrive asynchronously.
// Notes: Timing figures are kept in their own units and converted to cycles here.
package hbc_pkg;
  localparam int CLK_FREQ_MHZ = 40;
  localparam int CLK_PERIOD_NS = 25;
  localparam int EN_DEGLITCH_NS = 150;
  localparam int EN_DEGLITCH_CYC = (EN_DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OC_DEGLITCH_NS = 1000;
  localparam int OC_DEGLITCH_CYC = (OC_DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DETECT_TIME_US = 300;
  localparam int DETECT_CYC = DETECT_TIME_US * CLK_FREQ_MHZ;
  localparam int START_DELAY_US = 230;
  localparam int START_DELAY_CYC = START_DELAY_US * CLK_FREQ_MHZ;
  localparam int OFF_TIME_MS = 1;
  localparam int OFF_TIME_CYC = OFF_TIME_MS * 1000 * CLK_FREQ_MHZ;
  localparam int RETRY_TIME_MS = 1;
  localparam int RETRY_TIME_CYC = RETRY_TIME_MS * 1000 * CLK_FREQ_MHZ;
  // Synchroniser lane positions
  localparam int SY_EN = 0;
  localparam int SY_CTRL_A = 1;
  localparam int SY_CTRL_B = 2;
  localparam int SY_TRIP = 3;
  localparam int SY_OC = 4;
  localparam int SY_OV = 5;
  localparam int SY_OT = 6;
  localparam int SY_VLOW = 7;
  localparam int SY_VOK = 8;
  localparam int SY_TRIP_SETTING_PIN = 9;
  localparam int SY_W = 10;
  // Register map (byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_TRIPCNT = 8'h08;
  localparam int CTRL_SOFT_DIS = 0;
  localparam logic CTRL_RESET = 1'h0;
  localparam int ST_STATE_LSB = 0;
  localparam int ST_EN = 3;
  localparam int ST_UV = 4;
  localparam int ST_OV = 5;
  localparam int ST_OT = 6;
  localparam int ST_FAULT = 7;
  localparam int ST_TRIP_LOW = 8;
  localparam int ST_FIRST_DONE = 9;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_START = 3'b001,
    ST_RUN = 3'b010,
    ST_TRIP = 3'b011,
    ST_OCP = 3'b100
  } hbc_state_e;
endpackage : hbc_pkg

// File: hbc_top.sv
// Purpose: Control and protection logic for a two half-bridge motor driver.
// Assumes: Analog thresholds arrive as comparator levels; AXI4-Lite master on same clock.
// Notes: Each half-bridge output is a level plus drive enable; no enable means Z.
//
// Our own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module hbc_top
  import hbc_pkg::*;
#(
  // Spans are cycle counts so a bench may shorten them
  parameter int unsigned START_CYC = START_DELAY_CYC,
  parameter int unsigned DETECT_WIN_CYC = DETECT_CYC,
  parameter int unsigned OFF_CYC = OFF_TIME_CYC,
  parameter int unsigned RETRY_CYC = RETRY_TIME_CYC
) (
  input wire logic CORE_CLK_IN, // 40 MHz core clock
  input wire logic RST_N_IN, // Synchronous reset, active low
  input wire logic CLK_EN_IN, // Freezes all state while low
  input wire logic ENABLE_IN, // Device enable pin
  input wire logic BRIDGE_CTRL_A_IN, // Output A control pin
  input wire logic BRIDGE_CTRL_B_IN, // Output B control pin
  input wire logic TRIP_THRESHOLD_HIT_IN, // Sense feedback reached trip threshold
  input wire logic OVERCURRENT_LEVEL_IN, // Transistor current above over-current level
  input wire logic OVERVOLTAGE_PROTECT_IN, // Input supply above over-voltage threshold
  input wire logic OVERTEMP_IN, // Die over-temperature indication
  input wire logic SUPPLY_BELOW_OFF_IN, // Internal supply below 4.8V
  input wire logic SUPPLY_ABOVE_ON_IN, // Internal supply above 5.1V
  input wire logic TRIP_SETTING_PIN_IN, // High when a setting resistor is detected
  output logic BRIDGE_OUT_A_OUT, // Output A level when driven
  output logic BRIDGE_OUT_A_OE_OUT, // Output A driven; low means Z
  output logic BRIDGE_OUT_B_OUT, // Output B level when driven
  output logic BRIDGE_OUT_B_OE_OUT, // Output B driven; low means Z
  output logic FAULT_FLAG_N_OUT, // Open-drain fault flag level (always 0)
  output logic FAULT_FLAG_N_OE_OUT, // High while pulling the fault flag low
  output logic TRIP_THRESHOLD_LOW_OUT, // Selects reduced trip threshold
  input wire logic [7:0] S_AXI_AWADDR, // Write address
  input wire logic S_AXI_AWVALID, // Write address valid
  output logic S_AXI_AWREADY, // Write address ready
  input wire logic [31:0] S_AXI_WDATA, // Write data
  input wire logic [3:0] S_AXI_WSTRB, // Write byte strobes
  input wire logic S_AXI_WVALID, // Write data valid
  output logic S_AXI_WREADY, // Write data ready
  output logic [1:0] S_AXI_BRESP, // Write response
  output logic S_AXI_BVALID, // Write response valid
  input wire logic S_AXI_BREADY, // Write response ready
  input wire logic [7:0] S_AXI_ARADDR, // Read address
  input wire logic S_AXI_ARVALID, // Read address valid
  output logic S_AXI_ARREADY, // Read address ready
  output logic [31:0] S_AXI_RDATA, // Read data
  output logic [1:0] S_AXI_RRESP, // Read response
  output logic S_AXI_RVALID, // Read data valid
  input wire logic S_AXI_RREADY // Read data ready
);

  // All state lives in one word: one process fills next_r, one registers it
  typedef struct packed {
    logic [SY_W-1:0] sync1;
    logic [SY_W-1:0] sync2;
    logic en_filt;
    logic [2:0] en_cnt;
    hbc_state_e state;
    logic [15:0] tmr;
    logic [7:0] oc_cnt;
    logic uv;
    logic first_done;
    logic trip_low;
    logic out_a;
    logic out_a_oe;
    logic out_b;
    logic out_b_oe;
    logic fault_oe;
    logic soft_dis;
    logic [15:0] trip_count;
    logic aw_got;
    logic w_got;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } hbc_regs_s;

  hbc_regs_s r;
  hbc_regs_s next_r;

  logic [SY_W-1:0] raw_in;
  logic en_s;
  logic ctrl_a_s;
  logic ctrl_b_s;
  logic trip_s;
  logic oc_s;
  logic ov_s;
  logic ot_s;
  logic drive_ok;
  logic fault_act;
  logic trip_event;
  logic wr_fire;
  logic [31:0] status_word;

  // Undriven control pins read low through the on-pin pulldown
  assign raw_in = {TRIP_SETTING_PIN_IN, SUPPLY_ABOVE_ON_IN, SUPPLY_BELOW_OFF_IN,
                   OVERTEMP_IN, OVERVOLTAGE_PROTECT_IN, OVERCURRENT_LEVEL_IN,
                   TRIP_THRESHOLD_HIT_IN, BRIDGE_CTRL_B_IN, BRIDGE_CTRL_A_IN, ENABLE_IN};

  assign en_s = r.sync2[SY_EN];
  assign ctrl_a_s = r.sync2[SY_CTRL_A];
  assign ctrl_b_s = r.sync2[SY_CTRL_B];
  assign trip_s = r.sync2[SY_TRIP];
  assign oc_s = r.sync2[SY_OC];
  assign ov_s = r.sync2[SY_OV];
  assign ot_s = r.sync2[SY_OT];

  // Ready outputs are combinational so a request is taken in the cycle it appears;
  // they drop while the clock enable is low, since no state may move then.

  assign S_AXI_AWREADY = CLK_EN_IN && !r.aw_got && !r.bvalid;
  assign S_AXI_WREADY = CLK_EN_IN && !r.w_got && !r.bvalid;
  assign S_AXI_ARREADY = CLK_EN_IN && !r.rvalid;

  // Status is a live view; over-voltage and over-temperature come from the synchronisers
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[ST_STATE_LSB +: 3] = r.state;
    status_word[ST_EN] = r.en_filt;
    status_word[ST_UV] = r.uv;
    status_word[ST_OV] = ov_s;
    status_word[ST_OT] = ot_s;
    status_word[ST_FAULT] = r.fault_oe;
    status_word[ST_TRIP_LOW] = r.trip_low;
    status_word[ST_FIRST_DONE] = r.first_done;
  end

  always_comb begin
    next_r = r;
    drive_ok = 1'b0;
    fault_act = 1'b0;
    trip_event = 1'b0;
    wr_fire = 1'b0;

    // Two-stage synchronisers; stage one feeds stage two only
    next_r.sync1 = raw_in;
    next_r.sync2 = r.sync1;

    // Enable deglitch: a change must persist before it is accepted
    if (en_s == r.en_filt) begin
      next_r.en_cnt = 3'h0;
    end else if (r.en_cnt == 3'(EN_DEGLITCH_CYC - 1)) begin
      next_r.en_filt = en_s;
      next_r.en_cnt = 3'h0;
    end else begin
      next_r.en_cnt = r.en_cnt + 3'h1;
    end

    // Supply lockout with hysteresis between the two comparators
    if (r.sync2[SY_VLOW]) begin
      next_r.uv = 1'b1;
    end else if (r.sync2[SY_VOK]) begin
      next_r.uv = 1'b0;
    end


    // One shared down-counter times start-up, off time and retry; only one runs at once
    if (r.tmr != 16'h0000) begin
      next_r.tmr = r.tmr - 16'h0001;
    end


    // Sequencer: OFF waits for enable, START holds the bridge off, RUN drives it,
    // TRIP and OVERCURRENT_PROTECT hold it off for their own spans before returning to RUN.
    unique case (r.state)
      ST_OFF: begin
        if (r.en_filt && !r.uv) begin
          next_r.state = ST_START;
          // Resistor detection only on the very first start
          next_r.tmr = r.first_done ? 16'(START_CYC) : 16'(DETECT_WIN_CYC);
        end
      end
      ST_START: begin
        if (r.tmr <= 16'h0001) begin
          next_r.state = ST_RUN;
          if (!r.first_done) begin
            next_r.first_done = 1'b1;
            next_r.trip_low = r.sync2[SY_TRIP_SETTING_PIN];
          end
        end
      end
      ST_RUN: begin
        if (trip_s) begin
          next_r.state = ST_TRIP;
          next_r.tmr = 16'(OFF_CYC);
          trip_event = 1'b1;
        end else if (r.oc_cnt == 8'(OC_DEGLITCH_CYC - 1) && oc_s) begin
          next_r.state = ST_OCP;
          next_r.tmr = 16'(RETRY_CYC);
        end
      end
      ST_TRIP: begin
        if (r.tmr <= 16'h0001) begin
          next_r.state = ST_RUN;
        end
      end
      ST_OCP: begin
        if (r.tmr <= 16'h0001) begin
          next_r.state = ST_RUN;
        end
      end
      default: begin
        next_r.state = ST_OFF;
      end
    endcase


    // Over-current persistence counter runs only in the RUN state
    // A trip in the same cycle wins, so the count restarts after the off time
    if (r.state == ST_RUN && oc_s && next_r.state == ST_RUN) begin
      next_r.oc_cnt = r.oc_cnt + 8'h01;
    end else begin
      next_r.oc_cnt = 8'h00;
    end


    // Supply loss is a power reset: restart from the start-up wait
    if (r.uv) begin
      next_r.state = ST_OFF;
      next_r.tmr = 16'h0000;
    end
    // Enable low is shutdown and overrides everything
    if (!r.en_filt) begin
      next_r.state = ST_OFF;
      next_r.tmr = 16'h0000;
    end


    // Outputs are registered, so a control change shows three cycles after the pin:
    // two synchroniser stages and the output register.
    // Levels follow control inputs for as long as held, no refresh
    drive_ok = (r.state == ST_RUN) && !ov_s && !ot_s && !r.soft_dis;
    next_r.out_a = drive_ok && ctrl_a_s;
    next_r.out_b = drive_ok && ctrl_b_s;
    next_r.out_a_oe = drive_ok;
    next_r.out_b_oe = drive_ok;


    // Supply lockout leaves the flag released; it is a power reset, not a fault.
    // Flag pulls low for any active protection while enabled, released otherwise
    fault_act = r.en_filt &&
                (r.state == ST_TRIP || r.state == ST_OCP || ov_s || ot_s);
    next_r.fault_oe = fault_act;


    // Writes hold one request: AWREADY and WREADY stay low until the response is taken
    // Register bus: address and data are taken in either order
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      next_r.aw_got = 1'b1;
      next_r.aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      next_r.w_got = 1'b1;
      next_r.w_data = S_AXI_WDATA;
      next_r.w_strb = S_AXI_WSTRB;
    end
    if (r.aw_got && r.w_got) begin
      wr_fire = 1'b1;
      next_r.aw_got = 1'b0;
      next_r.w_got = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = RESP_OKAY;
      unique case (r.aw_addr)
        REG_CTRL: begin
          if (r.w_strb[0]) begin
            next_r.soft_dis = r.w_data[CTRL_SOFT_DIS];
          end
        end
        REG_STATUS: begin
        end
        REG_TRIPCNT: begin
          next_r.trip_count = 16'h0000;
        end
        default: begin
          next_r.bresp = RESP_SLVERR;
        end
      endcase
    end else if (r.bvalid && S_AXI_BREADY) begin
      next_r.bvalid = 1'b0;
    end


    // Trip counter: a trip in the clearing cycle still counts
    if (trip_event) begin
      if (wr_fire && r.aw_addr == REG_TRIPCNT) begin
        next_r.trip_count = 16'h0001;
      end else if (r.trip_count != 16'hFFFF) begin
        next_r.trip_count = r.trip_count + 16'h0001;
      end
    end


    // Read data is captured at acceptance and held until RREADY
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      next_r.rvalid = 1'b1;
      next_r.rresp = RESP_OKAY;
      unique case (S_AXI_ARADDR)
        REG_CTRL: next_r.rdata = {31'h0000_0000, r.soft_dis};
        REG_STATUS: next_r.rdata = status_word;
        REG_TRIPCNT: next_r.rdata = {16'h0000, r.trip_count};
        default: begin
          next_r.rdata = 32'h0000_0000;
          next_r.rresp = RESP_SLVERR;
        end
      endcase
    end else if (r.rvalid && S_AXI_RREADY) begin
      next_r.rvalid = 1'b0;
    end
  end

  // Reset clears the whole state; the clock enable freezes it as one word
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      r <= '0;
      r.state <= ST_OFF;
      r.soft_dis <= CTRL_RESET;
      r.bresp <= RESP_OKAY;
      r.rresp <= RESP_OKAY;
    end else if (CLK_EN_IN) begin
      r <= next_r;
    end
  end

  assign BRIDGE_OUT_A_OUT = r.out_a;
  assign BRIDGE_OUT_A_OE_OUT = r.out_a_oe;
  assign BRIDGE_OUT_B_OUT = r.out_b;
  assign BRIDGE_OUT_B_OE_OUT = r.out_b_oe;
  // Open drain: the level is always low, only the enable moves
  assign FAULT_FLAG_N_OUT = 1'b0;
  assign FAULT_FLAG_N_OE_OUT = r.fault_oe;
  assign TRIP_THRESHOLD_LOW_OUT = r.trip_low;
  assign S_AXI_BVALID = r.bvalid;
  assign S_AXI_BRESP = r.bresp;
  assign S_AXI_RVALID = r.rvalid;
  assign S_AXI_RDATA = r.rdata;
  assign S_AXI_RRESP = r.rresp;

endmodule : hbc_top
`default_nettype wire

// File: hbc_assertions.sv
// Purpose: Pin-level checks on hbc_top.
// Assumes: Inputs pass two sync flops and a register before reaching the pins.
// Notes: Counters stand in for long repetitions.
`timescale 1ns/100ps
`default_nettype none
module hbc_assertions (
  input wire logic CORE_CLK_IN, // Clock
  input wire logic RST_N_IN, // Reset
  input wire logic ENABLE_IN, // Enable
  input wire logic BRIDGE_CTRL_A_IN, // Control A
  input wire logic TRIP_THRESHOLD_HIT_IN, // Trip
  input wire logic OVERCURRENT_LEVEL_IN, // Over-current
  input wire logic OVERVOLTAGE_PROTECT_IN, // Over-voltage
  input wire logic OVERTEMP_IN, // Hot
  input wire logic SUPPLY_BELOW_OFF_IN, // Supply low
  input wire logic BRIDGE_OUT_A_OUT, // Level A
  input wire logic BRIDGE_OUT_A_OE_OUT, // Drive A
  input wire logic BRIDGE_OUT_B_OE_OUT, // Drive B
  input wire logic FAULT_FLAG_N_OUT, // Flag level
  input wire logic FAULT_FLAG_N_OE_OUT // Flag pull
);
  logic [7:0] en_lo, en_hi, oc_n;
  wire oe = BRIDGE_OUT_A_OE_OUT;
  wire fo = FAULT_FLAG_N_OE_OUT;
  // Saturating run lengths, so a long hold never wraps back to a small count
  always_ff @(posedge CORE_CLK_IN) begin
    en_lo <= (!RST_N_IN || ENABLE_IN) ? 8'h00 : en_lo + {7'h00, en_lo != 8'hFF};
    en_hi <= (!RST_N_IN || !ENABLE_IN) ? 8'h00 : en_hi + {7'h00, en_hi != 8'hFF};
    oc_n <= (!RST_N_IN || !OVERCURRENT_LEVEL_IN) ? 8'h00 : oc_n + {7'h00, oc_n != 8'hFF};
  end
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  a_shut_off: assert property (en_lo > 8'h0C |-> !oe && !fo)
    else $error("bridge or flag active while disabled");
  a_follow_a: assert property (oe && $past(oe, 3)
    |-> BRIDGE_OUT_A_OUT == $past(BRIDGE_CTRL_A_IN, 3)) else $error("output A level wrong");
  a_oe_pair: assert property (oe == BRIDGE_OUT_B_OE_OUT)
    else $error("half-bridges split");
  a_trip_cut: assert property ($rose(TRIP_THRESHOLD_HIT_IN) && oe |-> ##[1:4] (!oe && fo))
    else $error("trip did not cut bridge");
  a_trip_hold: assert property ($rose(TRIP_THRESHOLD_HIT_IN) && oe |-> ##5 (!oe) [*8])
    else $error("off time too short");
  a_prot_cut: assert property (((OVERVOLTAGE_PROTECT_IN || OVERTEMP_IN) && en_hi > 8'h28) [*4]
    |-> !oe && fo) else $error("protection not applied");
  a_flag_od: assert property (!FAULT_FLAG_N_OUT)
    else $error("flag drives high");
  a_quiet_start: assert property ($rose(ENABLE_IN) && en_lo > 8'h0C |-> (!oe) [*8])
    else $error("switching too soon");
  a_oc_shut: assert property (oc_n == 8'h2F && $past(oe, 47) |-> !oe && fo)
    else $error("over-current not shut");
  a_uv_cut: assert property (SUPPLY_BELOW_OFF_IN [*6] |-> !oe)
    else $error("bridge on with supply low");
  c_run: cover property ($rose(oe));
  c_trip: cover property ($rose(TRIP_THRESHOLD_HIT_IN) && oe);
  c_oc: cover property (oc_n == 8'h2F);
endmodule : hbc_assertions
bind hbc_top hbc_assertions u_chk (.CORE_CLK_IN(CORE_CLK_IN), .RST_N_IN(RST_N_IN),
  .ENABLE_IN(ENABLE_IN), .BRIDGE_CTRL_A_IN(BRIDGE_CTRL_A_IN),
  .TRIP_THRESHOLD_HIT_IN(TRIP_THRESHOLD_HIT_IN), .OVERCURRENT_LEVEL_IN(OVERCURRENT_LEVEL_IN),
  .OVERVOLTAGE_PROTECT_IN(OVERVOLTAGE_PROTECT_IN), .OVERTEMP_IN(OVERTEMP_IN),
  .SUPPLY_BELOW_OFF_IN(SUPPLY_BELOW_OFF_IN), .BRIDGE_OUT_A_OUT(BRIDGE_OUT_A_OUT),
  .BRIDGE_OUT_A_OE_OUT(BRIDGE_OUT_A_OE_OUT), .BRIDGE_OUT_B_OE_OUT(BRIDGE_OUT_B_OE_OUT),
  .FAULT_FLAG_N_OUT(FAULT_FLAG_N_OUT), .FAULT_FLAG_N_OE_OUT(FAULT_FLAG_N_OE_OUT));
`default_nettype wire

// File: hbc_host_model.sv
// Purpose: Host driver for the enable and output control pins.
// Assumes: Called just after a core clock edge.
// Notes: Control pins have pull-downs.
`timescale 1ns/100ps
`default_nettype none
module hbc_host_model (
  input wire logic clk_in, // Clock
  output logic en_out, // Enable pin
  output logic ctrl_a_out, // Control A
  output logic ctrl_b_out // Control B
);
  initial begin
    en_out = 1'b0;
    ctrl_a_out = 1'b0;
    ctrl_b_out = 1'b0;
  end
  // Level holds until the next call; callers keep spans long
  task set_en(input logic v);
    @(posedge clk_in);
    en_out <= v;
  endtask : set_en
  task set_ctrl(input logic a, input logic b);
    ctrl_a_out <= a;
    ctrl_b_out <= b;
  endtask : set_ctrl
  // Released pins settle at the pull-down level
  task float_ctrl();
    ctrl_a_out <= 1'b0;
    ctrl_b_out <= 1'b0;
  endtask : float_ctrl
endmodule : hbc_host_model
`default_nettype wire

// File: hbc_top_tb_top.sv
// Purpose: Self-checking bench for hbc_top.
// Assumes: Counts shortened by parameters.
// Notes: Spans are judged against the parameters set here.
`timescale 1ns/100ps
`default_nettype none
module hbc_top_tb_top;
  import hbc_pkg::*;
  localparam int SC = 20;
  localparam int DW = 30;
  localparam int OF = 25;
  localparam int RC = 35;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic en, ca, cb, oa, oae, ob, obe, fle, tlo, awr, wr, bv, arr, rv, sfl, x, y;
  logic trip = 1'b0, ocl = 1'b0, overvoltage_protect = 1'b0, ot = 1'b0, ulo = 1'b0, uok = 1'b1;
  logic awv = 1'b0, wv = 1'b0, brd = 1'b0, arv = 1'b0, rrd = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rd, r;
  logic [1:0] br, rr;
  logic ce = 1'b1, trip_setting_pin = 1'b1, fl;
  logic [3:0] ws = 4'hF;
  int error_cnt = 0, n_checks = 0, n, m_run = 0;
  int seed = 32'hB64720BA;
  hbc_host_model host (.clk_in(clk), .en_out(en), .ctrl_a_out(ca), .ctrl_b_out(cb));
  hbc_top #(.START_CYC(SC), .DETECT_WIN_CYC(DW), .OFF_CYC(OF), .RETRY_CYC(RC)) dut (
    .CORE_CLK_IN(clk), .RST_N_IN(rst_n), .CLK_EN_IN(ce), .ENABLE_IN(en),
    .BRIDGE_CTRL_A_IN(ca), .BRIDGE_CTRL_B_IN(cb), .TRIP_THRESHOLD_HIT_IN(trip),
    .OVERCURRENT_LEVEL_IN(ocl), .OVERVOLTAGE_PROTECT_IN(overvoltage_protect), .OVERTEMP_IN(ot),
    .SUPPLY_BELOW_OFF_IN(ulo), .SUPPLY_ABOVE_ON_IN(uok), .TRIP_SETTING_PIN_IN(trip_setting_pin),
    .BRIDGE_OUT_A_OUT(oa), .BRIDGE_OUT_A_OE_OUT(oae), .BRIDGE_OUT_B_OUT(ob),
    .BRIDGE_OUT_B_OE_OUT(obe), .FAULT_FLAG_N_OUT(fl), .FAULT_FLAG_N_OE_OUT(fle),
    .TRIP_THRESHOLD_LOW_OUT(tlo), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wr), .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(brd),
    .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rd),
    .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rrd));
  initial begin
    forever #12.5 clk = ~clk;
  end
  task ck(input logic [33:0] g, input logic [33:0] e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : ck
  task cyc(input int k);
    repeat (k) @(posedge clk);
  endtask : cyc
  // Waits for the bridge drive to reach v; the flag is captured at that moment
  task wfor(input logic v, input int lim);
    n = 0;
    @(negedge clk);
    while (oae !== v && n < lim) begin
      @(negedge clk);
      n++;
    end
    sfl = fle;
    ck(n < lim, 1'b1);
    @(posedge clk);
  endtask : wfor
  task wrr(input logic [7:0] a, input logic [31:0] d);
    logic ah, wh, bh;
    logic [1:0] rs;
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    brd <= 1'b1;
    n = 0;
    do begin
      @(negedge clk);
      ah = awv && awr;
      wh = wv && wr;
      bh = bv;
      rs = br;
      @(posedge clk);
      if (ah) awv <= 1'b0;
      if (wh) wv <= 1'b0;
      n++;
    end while (!bh && n < 40);
    brd <= 1'b0;
    ck({bh, rs}, {1'b1, RESP_OKAY});
  endtask : wrr
  task rdr(input logic [7:0] a, input logic [1:0] er, input logic [31:0] ed, input logic [31:0] m);
    logic ah, rh;
    logic [31:0] d;
    logic [1:0] rs;
    ara <= a;
    arv <= 1'b1;
    rrd <= 1'b1;
    n = 0;
    do begin
      @(negedge clk);
      ah = arv && arr;
      rh = rv;
      d = rd;
      rs = rr;
      @(posedge clk);
      if (ah) arv <= 1'b0;
      n++;
    end while (!rh && n < 40);
    rrd <= 1'b0;
    ck({rs, d & m}, {er, ed});
  endtask : rdr
  task finish_test();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test
  initial begin
    repeat (6000) @(posedge clk);
    error_cnt++;
    finish_test();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    ck({oae, obe, fle, fl}, 4'b0000);
    @(posedge clk);
    rdr(REG_STATUS, RESP_OKAY, 32'h0, 32'h3FF);
    rdr(8'h0C, RESP_SLVERR, 32'h0, 32'hFFFFFFFF);
    host.set_en(1'b1);
    cyc(3);
    host.set_en(1'b0);
    cyc(30);
    rdr(REG_STATUS, RESP_OKAY, 32'h0, 32'h0F);
    host.set_en(1'b1);
    wfor(1'b1, DW + 60);
    ck(n >= DW && n <= DW + 16, 1'b1);
    ck(tlo, 1'b1);
    rdr(REG_STATUS, RESP_OKAY, 32'h202, 32'h207);
    m_run = 1;
    for (int i = 0; i < 10; i++) begin
      r = $random(seed);
      x = r[0] && i < 9;
      y = r[1] && i < 9;
      if (i < 9) host.set_ctrl(x, y);
      else host.float_ctrl();
      cyc(4);
      @(negedge clk);
      ck({oae, obe, oa, ob}, {m_run[0], m_run[0], x, y});
      @(posedge clk);
    end
    host.set_ctrl(1'b1, 1'b0);
    cyc(300);
    @(negedge clk);
    ck({oae, oa}, 2'b11);
    @(posedge clk);
    // Clock enable low freezes the bridge and drops every bus ready
    ce <= 1'b0;
    cyc(10);
    @(negedge clk);
    ck({oae, oa, arr, awr, wr}, 5'b11000);
    @(posedge clk);
    ce <= 1'b1;
    trip <= 1'b1;
    cyc(3);
    trip <= 1'b0;
    wfor(1'b0, 4);
    ck(sfl, 1'b1);
    wfor(1'b1, OF + 12);
    ck(n >= OF - 4, 1'b1);
    rdr(REG_TRIPCNT, RESP_OKAY, 32'h1, 32'hFFFF);
    wrr(REG_TRIPCNT, 32'h0);
    rdr(REG_TRIPCNT, RESP_OKAY, 32'h0, 32'hFFFF);
    // Soft disable floats the bridge; a write without byte 0 strobe leaves it set
    wrr(REG_CTRL, 32'h1);
    cyc(3);
    @(negedge clk);
    ck({oae, obe}, 2'b00);
    @(posedge clk);
    ws <= 4'h0;
    wrr(REG_CTRL, 32'h0);
    ws <= 4'hF;
    rdr(REG_CTRL, RESP_OKAY, 32'h1, 32'hFFFFFFFF);
    wrr(REG_CTRL, 32'h0);
    wfor(1'b1, 8);
    ck(sfl, 1'b0);
    ocl <= 1'b1;
    wfor(1'b0, 60);
    ck(n >= OC_DEGLITCH_CYC && sfl, 1'b1);
    ocl <= 1'b0;
    wfor(1'b1, RC + SC + 30);
    ck(n >= RC - 4 && !sfl, 1'b1);
    for (int i = 0; i < 2; i++) begin
      overvoltage_protect <= (i == 0);
      ot <= (i == 1);
      cyc(12);
      @(negedge clk);
      ck({oae, fle}, 2'b01);
      @(posedge clk);
      overvoltage_protect <= 1'b0;
      ot <= 1'b0;
      wfor(1'b1, SC + 40);
      ck(sfl, 1'b0);
    end
    ulo <= 1'b1;
    uok <= 1'b0;
    wfor(1'b0, 8);
    ulo <= 1'b0;
    cyc(SC + 20);
    @(negedge clk);
    ck(oae, 1'b0);
    @(posedge clk);
    uok <= 1'b1;
    wfor(1'b1, SC + 30);
    ck(n >= SC, 1'b1);
    host.set_en(1'b0);
    wfor(1'b0, 16);
    ck(sfl, 1'b0);
    cyc(20);
    // Second reset after shutdown: a fresh first start with no setting resistor
    trip_setting_pin <= 1'b0;
    rst_n <= 1'b0;
    cyc(2);
    rst_n <= 1'b1;
    @(negedge clk);
    ck({oae, obe, fle, tlo}, 4'b0000);
    @(posedge clk);
    host.set_en(1'b1);
    wfor(1'b1, DW + 60);
    ck(n >= DW && tlo == 1'b0, 1'b1);
    cyc(20);
    finish_test();
  end
endmodule : hbc_top_tb_top
`default_nettype wire
